// ==== rtl/dtc_edge_sampler.sv ====
// Samples one input once per machine cycle and flags a 1-to-0 change
// between two successive samples.
// Assumes the input is synchronous to the core clock.
`timescale 1ns/100ps
`default_nettype none
module dtc_edge_sampler
  import dtc_pkg::*;
(
  input  wire logic clk_i,
  input  wire logic rst_i,
  input  wire logic tick_i,
  input  wire logic sig_i,
  output var  logic level_o,
  output var  logic fall_o
);

  logic smp_ff;
  logic fall_ff;

  // ---------------------------------------------------------------------------
  // Sampling
  // ---------------------------------------------------------------------------
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      smp_ff <= 1'b1;
    end else if (tick_i) begin
      smp_ff <= sig_i;
    end
  end

  // A fall needs a high sample and then a low one, so two machine cycles.
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      fall_ff <= 1'b0;
    end else begin
      fall_ff <= tick_i && smp_ff && !sig_i;
    end
  end

  assign level_o = smp_ff;
  assign fall_o  = fall_ff;

  property p_fall_two_samples;
    @(posedge clk_i) disable iff (rst_i)
      fall_o |-> $past(tick_i) && !$past(sig_i) && !level_o;
  endproperty
  a_fall_two_samples: assert property (p_fall_two_samples)
    else $error("Fall flagged without a high then low sample.");

endmodule
`default_nettype wire

// ==== rtl/dtc_top.sv ====
// Dual 16-bit timer/counter with external interrupt flags, as a classic
// Wishbone slave with 32-bit data.
// Assumes count and interrupt pins are synchronous to MCLK_I and that the
// interrupt controller pulses the service inputs when it vectors.
//
// The Wishbone slave port was chosen for this implementation.
`timescale 1ns/100ps
`default_nettype none
module dtc_top
  import dtc_pkg::*;
(
  input  wire logic        MCLK_I,
  input  wire logic        SYS_RST_I,
  input  wire logic        WB_CYC_I,
  input  wire logic        WB_STB_I,
  input  wire logic        WB_WE_I,
  input  wire logic [11:0] WB_ADR_I,
  input  wire logic [3:0]  WB_SEL_I,
  input  wire logic [31:0] WB_DAT_I,
  output var  logic [31:0] WB_DAT_O,
  output var  logic        WB_ACK_O,
  input  wire logic        COUNT_INPUT_A_I,
  input  wire logic        COUNT_INPUT_B_I,
  input  wire logic        EXT_IRQ_PIN_A_I,
  input  wire logic        EXT_IRQ_PIN_B_I,
  input  wire logic        SVC_OVF_A_I,
  input  wire logic        SVC_OVF_B_I,
  input  wire logic        SVC_EXT_A_I,
  input  wire logic        SVC_EXT_B_I,
  output var  logic        OVF_FLAG_A_O,
  output var  logic        OVF_FLAG_B_O,
  output var  logic        EXT_IRQ_FLAG_A_O,
  output var  logic        EXT_IRQ_FLAG_B_O
);

  // ---------------------------------------------------------------------------
  // Declarations
  // ---------------------------------------------------------------------------
  logic [3:0]  presc_ff;
  logic        tick_ff;
  logic [7:0]  mode_ff;
  logic        run_a_ff, run_b_ff, type_a_ff, type_b_ff;
  logic        ovf_a_ff, ovf_b_ff, eif_a_ff, eif_b_ff;
  logic [7:0]  low_a_ff, high_a_ff, low_b_ff, high_b_ff;
  logic [7:0]  nxt_low_a, nxt_high_a, nxt_low_b, nxt_high_b;
  logic        ack_ff;
  logic [31:0] dat_ff;
  logic [31:0] rd_data;
  logic [3:0]  pin_level;
  logic [3:0]  pin_fall;
  logic [16:0] step_a, step_b;
  logic        evt_ovf_a, evt_ovf_b, evt_ovf_ha;
  logic        inc_a, inc_b, inc_ha;
  logic        wr_hit;
  logic        wr_ctrl, wr_mode, wr_low_a, wr_high_a, wr_low_b, wr_high_b;
  logic        set_ovf_a, set_ovf_b, set_eif_a, set_eif_b;
  dtc_mode_t   mode_a, mode_b;
  logic [9:0]  idx;

  assign idx    = WB_ADR_I[11:2];
  assign mode_a = dtc_mode_t'(mode_ff[MODE_SEL_A +: 2]);
  assign mode_b = dtc_mode_t'(mode_ff[MODE_SEL_B +: 2]);

  // ---------------------------------------------------------------------------
  // Functions
  // ---------------------------------------------------------------------------
  function automatic logic hit(input logic [9:0] a, input logic [9:0] which);
    return a == which;
  endfunction

  // Returns {overflow, high, low} after one count step in the given mode.
  function automatic logic [16:0] cnt_step(input dtc_mode_t m,
                                           input logic [7:0] lo,
                                           input logic [7:0] hi);
    logic [13:0] v13;
    logic [8:0]  v8;
    logic [16:0] r;
    v13 = {1'b0, hi, lo[4:0]} + 14'h0001;
    v8  = {1'b0, lo} + 9'h001;
    r   = {1'b0, hi, lo};
    unique case (m)
      DTC_MODE_13: begin
        r = {v13[13], v13[12:5], 3'b000, v13[4:0]};
      end
      DTC_MODE_16: begin
        r = {1'b0, hi, lo} + 17'h00001;
      end
      DTC_MODE_RELD: begin
        r = v8[8] ? {1'b1, hi, hi} : {1'b0, hi, v8[7:0]};
      end
      DTC_MODE_SPLIT: begin
        r = {v8[8], hi, v8[7:0]};
      end
    endcase
    return r;
  endfunction

  // ---------------------------------------------------------------------------
  // Machine cycle prescaler
  // ---------------------------------------------------------------------------
  always_ff @(posedge MCLK_I or posedge SYS_RST_I) begin
    if (SYS_RST_I) begin
      presc_ff <= 4'h0;
      tick_ff  <= 1'b0;
    end else begin
      tick_ff  <= presc_ff == (MC_DIV - 4'h1);
      presc_ff <= (presc_ff == (MC_DIV - 4'h1)) ? 4'h0 : presc_ff + 4'h1;
    end
  end

  // ---------------------------------------------------------------------------
  // Pin sampling: count inputs A, B and interrupt pins A, B
  // ---------------------------------------------------------------------------
  // Sources must hold each level a full machine cycle to be sure it is sampled.
  genvar gi;
  generate
    for (gi = 0; gi < 4; gi++) begin : g_pin
      dtc_edge_sampler u_smp (
        .clk_i   (MCLK_I),
        .rst_i   (SYS_RST_I),
        .tick_i  (tick_ff),
        .sig_i   ((gi == 0) ? COUNT_INPUT_A_I :
                  (gi == 1) ? COUNT_INPUT_B_I :
                  (gi == 2) ? EXT_IRQ_PIN_A_I : EXT_IRQ_PIN_B_I),
        .level_o (pin_level[gi]),
        .fall_o  (pin_fall[gi])
      );
    end
  endgenerate

  // ---------------------------------------------------------------------------
  // Count enables
  // ---------------------------------------------------------------------------
  // A gated unit counts input falls only while its run bit is set.
  assign inc_a  = run_a_ff && ((mode_ff[MODE_GATE_A] || mode_ff[MODE_CNT_A])
                               ? pin_fall[0] : tick_ff);
  assign inc_b  = run_b_ff && (mode_b != DTC_MODE_SPLIT)
                  && ((mode_ff[MODE_GATE_B] || mode_ff[MODE_CNT_B])
                      ? pin_fall[1] : tick_ff);
  // The split high byte borrows unit B's run bit and counts machine cycles.
  assign inc_ha = (mode_a == DTC_MODE_SPLIT) && run_b_ff && tick_ff;

  // ---------------------------------------------------------------------------
  // Bus decode
  // ---------------------------------------------------------------------------
  // Writes land on the edge that samples the acknowledge.
  assign wr_hit    = WB_CYC_I && WB_STB_I && WB_WE_I && ack_ff && WB_SEL_I[0];
  assign wr_ctrl   = wr_hit && hit(idx, IDX_CTRL);
  assign wr_mode   = wr_hit && hit(idx, IDX_MODE);
  assign wr_low_a  = wr_hit && hit(idx, IDX_LOW_A);
  assign wr_high_a = wr_hit && hit(idx, IDX_HIGH_A);
  assign wr_low_b  = wr_hit && hit(idx, IDX_LOW_B);
  assign wr_high_b = wr_hit && hit(idx, IDX_HIGH_B);

  always_comb begin
    rd_data = 32'h0000_0000;
    if (hit(idx, IDX_CTRL)) begin
      rd_data[7:0] = {ovf_b_ff, run_b_ff, ovf_a_ff, run_a_ff,
                      eif_b_ff, type_b_ff, eif_a_ff, type_a_ff};
    end else if (hit(idx, IDX_MODE)) begin
      rd_data[7:0] = mode_ff;
    end else if (hit(idx, IDX_LOW_A)) begin
      rd_data[7:0] = low_a_ff;
    end else if (hit(idx, IDX_HIGH_A)) begin
      rd_data[7:0] = high_a_ff;
    end else if (hit(idx, IDX_LOW_B)) begin
      rd_data[7:0] = low_b_ff;
    end else if (hit(idx, IDX_HIGH_B)) begin
      rd_data[7:0] = high_b_ff;
    end
  end

  // Every access, mapped or not, is acknowledged one cycle after the request.
  always_ff @(posedge MCLK_I or posedge SYS_RST_I) begin
    if (SYS_RST_I) begin
      ack_ff <= 1'b0;
      dat_ff <= 32'h0000_0000;
    end else begin
      ack_ff <= WB_CYC_I && WB_STB_I && !ack_ff;
      if (WB_CYC_I && WB_STB_I && !ack_ff) begin
        dat_ff <= rd_data;
      end
    end
  end

  // ---------------------------------------------------------------------------
  // Mode register and software control bits
  // ---------------------------------------------------------------------------
  always_ff @(posedge MCLK_I or posedge SYS_RST_I) begin
    if (SYS_RST_I) begin
      mode_ff <= MODE_RST;
    end else if (wr_mode) begin
      mode_ff <= WB_DAT_I[7:0];
    end
  end

  // Software alone starts, stops and sets the interrupt type of both units.
  always_ff @(posedge MCLK_I or posedge SYS_RST_I) begin
    if (SYS_RST_I) begin
      run_a_ff  <= CTRL_RST[CTRL_RUN_A];
      run_b_ff  <= CTRL_RST[CTRL_RUN_B];
      type_a_ff <= CTRL_RST[CTRL_EIT_A];
      type_b_ff <= CTRL_RST[CTRL_EIT_B];
    end else if (wr_ctrl) begin
      run_a_ff  <= WB_DAT_I[CTRL_RUN_A];
      run_b_ff  <= WB_DAT_I[CTRL_RUN_B];
      type_a_ff <= WB_DAT_I[CTRL_EIT_A];
      type_b_ff <= WB_DAT_I[CTRL_EIT_B];
    end
  end

  // ---------------------------------------------------------------------------
  // Count registers
  // ---------------------------------------------------------------------------
  assign step_a = cnt_step(mode_a, low_a_ff, high_a_ff);
  assign step_b = cnt_step(mode_b, low_b_ff, high_b_ff);

  always_comb begin
    nxt_low_a  = low_a_ff;
    nxt_high_a = high_a_ff;
    evt_ovf_a  = 1'b0;
    evt_ovf_ha = 1'b0;
    if (inc_a) begin
      nxt_low_a  = step_a[7:0];
      nxt_high_a = step_a[15:8];
      evt_ovf_a  = step_a[16];
    end
    if (inc_ha) begin
      {evt_ovf_ha, nxt_high_a} = {1'b0, high_a_ff} + 9'h001;
    end
    if (wr_low_a) begin
      nxt_low_a = WB_DAT_I[7:0];
    end
    if (wr_high_a) begin
      nxt_high_a = WB_DAT_I[7:0];
    end
    if (mode_a == DTC_MODE_13) begin
      nxt_low_a[7:5] = 3'b000;
    end
  end

  always_comb begin
    nxt_low_b  = low_b_ff;
    nxt_high_b = high_b_ff;
    evt_ovf_b  = 1'b0;
    if (inc_b) begin
      nxt_low_b  = step_b[7:0];
      nxt_high_b = step_b[15:8];
      evt_ovf_b  = step_b[16];
    end
    if (wr_low_b) begin
      nxt_low_b = WB_DAT_I[7:0];
    end
    if (wr_high_b) begin
      nxt_high_b = WB_DAT_I[7:0];
    end
    if (mode_b == DTC_MODE_13) begin
      nxt_low_b[7:5] = 3'b000;
    end
  end

  always_ff @(posedge MCLK_I or posedge SYS_RST_I) begin
    if (SYS_RST_I) begin
      low_a_ff  <= COUNT_RST;
      high_a_ff <= COUNT_RST;
      low_b_ff  <= COUNT_RST;
      high_b_ff <= COUNT_RST;
    end else begin
      low_a_ff  <= nxt_low_a;
      high_a_ff <= nxt_high_a;
      low_b_ff  <= nxt_low_b;
      high_b_ff <= nxt_high_b;
    end
  end

  // ---------------------------------------------------------------------------
  // Overflow and external interrupt flags
  // ---------------------------------------------------------------------------
  // In split mode unit B's flag belongs to unit A's high byte.
  assign set_ovf_a = evt_ovf_a;
  assign set_ovf_b = (mode_a == DTC_MODE_SPLIT) ? evt_ovf_ha : evt_ovf_b;
  assign set_eif_a = type_a_ff ? pin_fall[2] : !pin_level[2];
  assign set_eif_b = type_b_ff ? pin_fall[3] : !pin_level[3];

  // A set in the same cycle as a clear wins, so no overflow is lost.
  always_ff @(posedge MCLK_I or posedge SYS_RST_I) begin
    if (SYS_RST_I) begin
      ovf_a_ff <= CTRL_RST[CTRL_OVF_A];
      ovf_b_ff <= CTRL_RST[CTRL_OVF_B];
    end else begin
      if (set_ovf_a) begin
        ovf_a_ff <= 1'b1;
      end else if (SVC_OVF_A_I) begin
        ovf_a_ff <= 1'b0;
      end else if (wr_ctrl) begin
        ovf_a_ff <= WB_DAT_I[CTRL_OVF_A];
      end
      if (set_ovf_b) begin
        ovf_b_ff <= 1'b1;
      end else if (SVC_OVF_B_I) begin
        ovf_b_ff <= 1'b0;
      end else if (wr_ctrl) begin
        ovf_b_ff <= WB_DAT_I[CTRL_OVF_B];
      end
    end
  end

  // In level mode the flag tracks the sampled pin, so a service cannot hide
  // a pin that is still held low.
  always_ff @(posedge MCLK_I or posedge SYS_RST_I) begin
    if (SYS_RST_I) begin
      eif_a_ff <= CTRL_RST[CTRL_EIF_A];
      eif_b_ff <= CTRL_RST[CTRL_EIF_B];
    end else begin
      if (!type_a_ff) begin
        eif_a_ff <= set_eif_a;
      end else if (set_eif_a) begin
        eif_a_ff <= 1'b1;
      end else if (SVC_EXT_A_I) begin
        eif_a_ff <= 1'b0;
      end else if (wr_ctrl) begin
        eif_a_ff <= WB_DAT_I[CTRL_EIF_A];
      end
      if (!type_b_ff) begin
        eif_b_ff <= set_eif_b;
      end else if (set_eif_b) begin
        eif_b_ff <= 1'b1;
      end else if (SVC_EXT_B_I) begin
        eif_b_ff <= 1'b0;
      end else if (wr_ctrl) begin
        eif_b_ff <= WB_DAT_I[CTRL_EIF_B];
      end
    end
  end

  assign WB_DAT_O         = dat_ff;
  assign WB_ACK_O         = ack_ff;
  assign OVF_FLAG_A_O     = ovf_a_ff;
  assign OVF_FLAG_B_O     = ovf_b_ff;
  assign EXT_IRQ_FLAG_A_O = eif_a_ff;
  assign EXT_IRQ_FLAG_B_O = eif_b_ff;

  // ---------------------------------------------------------------------------
  // Assertions
  // ---------------------------------------------------------------------------
  property p_tick_period;
    @(posedge MCLK_I) disable iff (SYS_RST_I)
      tick_ff |=> !tick_ff [*8] ##1 !tick_ff [*3] ##1 tick_ff;
  endproperty
  a_tick_period: assert property (p_tick_period)
    else $error("Machine cycle tick is not every twelve clocks.");

  property p_count_on_fall;
    @(posedge MCLK_I) disable iff (SYS_RST_I)
      (pin_fall[0] && run_a_ff && (mode_ff[MODE_CNT_A] || mode_ff[MODE_GATE_A])
       && mode_a == DTC_MODE_16 && !wr_low_a && !wr_high_a)
      |=> low_a_ff == $past(low_a_ff) + 8'h01;
  endproperty
  a_count_on_fall: assert property (p_count_on_fall)
    else $error("Counter did not advance on an input fall.");

  property p_halt;
    @(posedge MCLK_I) disable iff (SYS_RST_I)
      (!run_a_ff && mode_a != DTC_MODE_SPLIT && !wr_low_a && !wr_high_a
       && (mode_a != DTC_MODE_13 || low_a_ff[7:5] == 3'b000))
      |=> $stable(low_a_ff) && $stable(high_a_ff);
  endproperty
  a_halt: assert property (p_halt)
    else $error("Unit A counted while its run bit was clear.");

  property p_mode13_mask;
    @(posedge MCLK_I) disable iff (SYS_RST_I)
      $past(mode_a) == DTC_MODE_13 |-> low_a_ff[7:5] == 3'b000;
  endproperty
  a_mode13_mask: assert property (p_mode13_mask)
    else $error("Upper low-byte bits not zero in 13-bit mode.");

  property p_reload;
    @(posedge MCLK_I) disable iff (SYS_RST_I)
      (inc_a && mode_a == DTC_MODE_RELD && low_a_ff == 8'hFF && !wr_low_a)
      |=> low_a_ff == $past(high_a_ff) && ovf_a_ff;
  endproperty
  a_reload: assert property (p_reload)
    else $error("Auto-reload did not copy high byte and flag overflow.");

  property p_b_stopped;
    @(posedge MCLK_I) disable iff (SYS_RST_I)
      (mode_b == DTC_MODE_SPLIT && !wr_low_b && !wr_high_b)
      |=> $stable(low_b_ff) && $stable(high_b_ff);
  endproperty
  a_b_stopped: assert property (p_b_stopped)
    else $error("Unit B counted in mode three.");

  property p_split_high_flag;
    @(posedge MCLK_I) disable iff (SYS_RST_I)
      (inc_ha && high_a_ff == 8'hFF && !wr_high_a)
      |=> ovf_b_ff && high_a_ff == 8'h00;
  endproperty
  a_split_high_flag: assert property (p_split_high_flag)
    else $error("Split high byte overflow did not set unit B flag.");

  property p_ovf_set_wins;
    @(posedge MCLK_I) disable iff (SYS_RST_I)
      set_ovf_a |=> ovf_a_ff;
  endproperty
  a_ovf_set_wins: assert property (p_ovf_set_wins)
    else $error("Overflow lost against a clear.");

  property p_level_irq;
    @(posedge MCLK_I) disable iff (SYS_RST_I)
      !type_a_ff |=> eif_a_ff == !$past(pin_level[2]);
  endproperty
  a_level_irq: assert property (p_level_irq)
    else $error("Level-mode flag does not follow the low pin.");

  property p_mode_write;
    @(posedge MCLK_I) disable iff (SYS_RST_I)
      wr_mode |=> mode_ff == $past(WB_DAT_I[7:0]);
  endproperty
  a_mode_write: assert property (p_mode_write)
    else $error("Mode register write not stored.");

endmodule
`default_nettype wire

// ==== shared/dtc_pkg.sv ====
// Constants for the dual timer/counter: register indices, bit positions,
// reset values and the machine-cycle divider.
// Assumes a single 100 MHz core clock and a 32-bit classic Wishbone slave port.
package dtc_pkg;

  // ---------------------------------------------------------------------------
  // Register indices (byte address is four times the index)
  // ---------------------------------------------------------------------------
  localparam logic [9:0] IDX_CTRL   = 10'h088;
  localparam logic [9:0] IDX_MODE   = 10'h089;
  localparam logic [9:0] IDX_LOW_A  = 10'h08A;
  localparam logic [9:0] IDX_HIGH_A = 10'h08B;
  localparam logic [9:0] IDX_LOW_B  = 10'h08C;
  localparam logic [9:0] IDX_HIGH_B = 10'h08D;

  // ---------------------------------------------------------------------------
  // Timer control register fields
  // ---------------------------------------------------------------------------
  localparam int CTRL_OVF_B = 7;
  localparam int CTRL_RUN_B = 6;
  localparam int CTRL_OVF_A = 5;
  localparam int CTRL_RUN_A = 4;
  localparam int CTRL_EIF_B = 3;
  localparam int CTRL_EIT_B = 2;
  localparam int CTRL_EIF_A = 1;
  localparam int CTRL_EIT_A = 0;

  // ---------------------------------------------------------------------------
  // Timer mode register fields
  // ---------------------------------------------------------------------------
  localparam int MODE_GATE_B = 7;
  localparam int MODE_CNT_B  = 6;
  localparam int MODE_SEL_B  = 4;
  localparam int MODE_GATE_A = 3;
  localparam int MODE_CNT_A  = 2;
  localparam int MODE_SEL_A  = 0;

  // ---------------------------------------------------------------------------
  // Reset values and timing
  // ---------------------------------------------------------------------------
  localparam logic [7:0] CTRL_RST  = 8'h00;
  localparam logic [7:0] MODE_RST  = 8'h00;
  localparam logic [7:0] COUNT_RST = 8'h00;
  // Core clocks per machine cycle.
  localparam logic [3:0] MC_DIV    = 4'hC;

  typedef enum logic [1:0] {
    DTC_MODE_13    = 2'b00,
    DTC_MODE_16    = 2'b01,
    DTC_MODE_RELD  = 2'b10,
    DTC_MODE_SPLIT = 2'b11
  } dtc_mode_t;

endpackage

// ==== testbench/dtc_top_bench.sv ====
// Self-checking bench for the dual timer/counter top level.
// Assumes dtc_pkg is compiled first; the bench drives every port itself.
`timescale 1ns/100ps
`default_nettype none
`define CHK(nm, ex, gt) begin tests_run++; if ((gt) !== (ex)) begin n_errors++; \
  $display("CHECK FAILED %s expected %h seen %h", nm, ex, gt); end end
module dtc_top_bench
  import dtc_pkg::*;
;
  logic        mclk = 1'b0;
  logic        rst = 1'b1;
  logic        cyc = 1'b0;
  logic        stb = 1'b0;
  logic        we = 1'b0;
  logic [11:0] adr = 12'h000;
  logic [3:0]  sel = 4'h0;
  logic [31:0] dat_w = 32'h0;
  logic [31:0] dat_r;
  logic        ack;
  logic        cin_a = 1'b1;
  logic        cin_b = 1'b1;
  logic        pin_a = 1'b1;
  logic        pin_b = 1'b1;
  logic        svc_a = 1'b0;
  logic        svc_e = 1'b0;
  logic        ovf_a;
  logic        ovf_b;
  logic        eif_a;
  logic        eif_b;
  logic [7:0]  exp_q[$];
  logic [7:0]  e_v;
  logic [7:0]  r_v;
  logic [7:0]  lo_t[4] = '{8'h1F, 8'hFF, 8'hFF, 8'hFF};
  logic [7:0]  hi_t[4] = '{8'hFF, 8'hFF, 8'hC0, 8'hFF};
  logic [7:0]  el_t[4] = '{8'h05, 8'h05, 8'hC5, 8'h05};
  logic [7:0]  eh_t[4] = '{8'h00, 8'h00, 8'hC0, 8'h05};
  int          n_errors = 0;
  int          tests_run = 0;
  int          cyc_cnt = 0;
  int          i;
  int          nf;

  dtc_top DUT (
    .MCLK_I(mclk), .SYS_RST_I(rst), .WB_CYC_I(cyc), .WB_STB_I(stb), .WB_WE_I(we),
    .WB_ADR_I(adr), .WB_SEL_I(sel), .WB_DAT_I(dat_w), .WB_DAT_O(dat_r), .WB_ACK_O(ack),
    .COUNT_INPUT_A_I(cin_a), .COUNT_INPUT_B_I(cin_b), .EXT_IRQ_PIN_A_I(pin_a),
    .EXT_IRQ_PIN_B_I(pin_b), .SVC_OVF_A_I(svc_a), .SVC_OVF_B_I(svc_a), .SVC_EXT_A_I(svc_e),
    .SVC_EXT_B_I(svc_e), .OVF_FLAG_A_O(ovf_a), .OVF_FLAG_B_O(ovf_b), .EXT_IRQ_FLAG_A_O(eif_a),
    .EXT_IRQ_FLAG_B_O(eif_b)
  );

  always #5 mclk = ~mclk;

  // ----------
  // Read results are judged where the bus answers, oldest note first.
  // ----------
  always @(posedge mclk) begin
    if (ack === 1'b1 && we === 1'b0 && exp_q.size() > 0) begin
      e_v = exp_q.pop_front();
      `CHK("read data", {24'h0, e_v}, dat_r)
    end
  end

  always @(posedge mclk) begin
    cyc_cnt++;
    if (cyc_cnt == 30000) begin
      n_errors++;
      give_verdict();
    end
  end

  task automatic give_verdict();
    $display("checks %0d mismatches %0d", tests_run, n_errors);
    if (n_errors == 0 && tests_run > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask

  // The request is held until ack is seen high at a rising edge.
  task automatic bus(input logic [9:0] idx, input logic w, input logic [7:0] d);
    @(posedge mclk);
    {cyc, stb, we, sel} <= {2'b11, w, 4'h1};
    adr <= {idx, 2'b00};
    dat_w <= {24'h0, d};
    @(posedge mclk);
    while (ack !== 1'b1) @(posedge mclk);
    {cyc, stb, we} <= 3'b000;
  endtask

  task automatic wr(input logic [9:0] idx, input logic [7:0] d);
    bus(idx, 1'b1, d);
  endtask

  task automatic rd(input logic [9:0] idx, input logic [7:0] ex);
    exp_q.push_back(ex);
    bus(idx, 1'b0, 8'h00);
  endtask

  initial begin
    void'($urandom(92684));
    repeat (20) @(posedge mclk);
    rst <= 1'b0;
    for (i = 0; i < 7; i++) rd(i == 6 ? 10'h000 : IDX_CTRL + 10'(i), 8'h00);
    $display("test reset done");
    r_v = 8'($urandom);
    if (r_v[1:0] == 2'b10) r_v[5:4] = 2'b10;
    wr(IDX_MODE, r_v);
    rd(IDX_MODE, r_v);
    wr(IDX_LOW_B, 8'hFF);
    rd(IDX_LOW_B, r_v[5:4] == 2'b00 ? 8'h1F : 8'hFF);
    $display("test register access done");
    // One row per mode of unit A; the count is read five ticks after the wrap.
    for (i = 0; i < 4; i++) begin
      wr(IDX_MODE, i == 2 ? 8'h22 : 8'(i));
      wr(IDX_LOW_A, lo_t[i]);
      wr(IDX_HIGH_A, hi_t[i]);
      wr(IDX_CTRL, i == 3 ? 8'h50 : 8'h10);
      nf = 0;
      while (ovf_a !== 1'b1 && nf < 40) begin
        @(negedge mclk);
        nf++;
      end
      `CHK("overflow a", 1'b1, ovf_a)
      `CHK("overflow b", 1'(i == 3), ovf_b)
      repeat (66) @(posedge mclk);
      rd(IDX_LOW_A, el_t[i]);
      rd(IDX_HIGH_A, eh_t[i]);
      svc_a <= 1'b1;
      @(posedge mclk);
      svc_a <= 1'b0;
      @(negedge mclk);
      `CHK("overflow a serviced", 1'b0, ovf_a)
      `CHK("overflow b serviced", 1'b0, ovf_b)
      wr(IDX_CTRL, 8'h00);
    end
    wr(IDX_LOW_A, 8'h33);
    repeat (40) @(posedge mclk);
    rd(IDX_LOW_A, 8'h33);
    $display("test timer modes done");
    // Unit A is gated in 16-bit mode, unit B counts in 16-bit mode.
    wr(IDX_MODE, 8'h59);
    wr(IDX_LOW_A, 8'h00);
    wr(IDX_HIGH_A, 8'h00);
    wr(IDX_LOW_B, 8'h00);
    wr(IDX_HIGH_B, 8'h00);
    wr(IDX_CTRL, 8'h50);
    nf = 1 + $urandom % 6;
    // Each level is held two machine cycles, twice the least a source may give.
    repeat (nf) begin
      {cin_a, cin_b} <= 2'b00;
      repeat (24) @(posedge mclk);
      {cin_a, cin_b} <= 2'b11;
      repeat (24) @(posedge mclk);
    end
    wr(IDX_CTRL, 8'h00);
    rd(IDX_LOW_B, 8'(nf));
    rd(IDX_LOW_A, 8'(nf));
    wr(IDX_MODE, 8'h30);
    wr(IDX_CTRL, 8'h40);
    repeat (60) @(posedge mclk);
    rd(IDX_LOW_B, 8'(nf));
    $display("test counter done");
    wr(IDX_CTRL, 8'h01);
    pin_a <= 1'b0;
    pin_b <= 1'b0;
    repeat (30) @(posedge mclk);
    pin_a <= 1'b1;
    pin_b <= 1'b1;
    @(negedge mclk);
    `CHK("edge flag a", 1'b1, eif_a)
    `CHK("level flag b", 1'b1, eif_b)
    repeat (30) @(negedge mclk);
    `CHK("edge flag a held", 1'b1, eif_a)
    `CHK("level flag b gone", 1'b0, eif_b)
    @(posedge mclk);
    svc_e <= 1'b1;
    @(posedge mclk);
    svc_e <= 1'b0;
    @(negedge mclk);
    `CHK("edge flag a serviced", 1'b0, eif_a)
    $display("test external flags done");
    give_verdict();
  end
endmodule
`default_nettype wire
